/* File: sim/io_port_mux_control_tb.sv */
`timescale 1ns/100ps
module io_port_mux_control_tb;
    import io_port_pkg::*;
    logic        clk, rst, wr_en, rd_en, ssp_en, usart_en, rd_pend;
    logic        timer_clock_in;
    logic [3:0]  addr;
    logic [7:0]  wdata, rd_data, l, d, m, lv;
    logic [5:0]  lv6, nl;
    logic [1:0]  ssp_drive, usart_out, usart_oe, pwm_en, pwm_out, ext_low;
    logic [1:0]  sync_serial_in, async_serial_in;
    logic [19:0] sysbus_out, sysbus_oe, sysbus_in;
    logic [49:0] pin_in, pin_out, pin_oe, ext_val, periph_pin_level, exp_oe;
    logic [31:0] seed, r;
    mode_t       mode;
    logic [7:0]  exp_q[$];
    int          errors, comparisons, cycles, b;
    int          base[6] = '{6, 14, 22, 30, 34, 42};

    io_port_mux_control uut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .mode(mode), .ssp_en(ssp_en), .ssp_drive(ssp_drive),
        .usart_en(usart_en), .usart_out(usart_out), .usart_oe(usart_oe),
        .pwm_en(pwm_en), .pwm_out(pwm_out), .sysbus_out(sysbus_out),
        .sysbus_oe(sysbus_oe), .sysbus_in(sysbus_in), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe),
        .timer_clock_in(timer_clock_in), .sync_serial_in(sync_serial_in),
        .async_serial_in(async_serial_in),
        .periph_pin_level(periph_pin_level));

    pin_board board (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .ext_low(ext_low), .pin_in(pin_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    task rnd(output logic [31:0] v);
        seed = lfsr(seed);
        v = seed;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Expectation queued now, compared by the monitor two cycles later
    task rd(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(v);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] msk(input int k);
        return (k == 3) ? 8'h0F : 8'hFF;
    endfunction

    always @(posedge clk) begin
        if (rd_pend) begin
            comparisons++;
            if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
                errors++;
                $display("mismatch at %0t: read data %h", $time, rd_data);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
        rd_pend <= rd_en;
    end

    // Whole run is well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            results();
        end
    end

    initial begin
        {rst, seed} = {1'b1, 32'hE50F};
        {wr_en, rd_en, addr, wdata, exp_oe} = '0;
        {ssp_en, usart_en, usart_out, usart_oe, pwm_en, pwm_out} = '0;
        {sysbus_out, sysbus_oe, ext_low} = '0;
        {ssp_drive, mode} = {2'h3, MODE_MC};
        rnd(r);
        ext_val[31:0] = r;
        rnd(r);
        ext_val[49:32] = r[17:0];
        tick(10);
        rst <= 1'b0;
        tick(1);
        @(negedge clk);
        // Latch resets low, so the open-drain pair pulls down
        chk(pin_oe === 50'hC, "enables after reset");
        chk($bits(uut.pin_in) == 50, "pin count");
        for (int k = 0; k < 6; k++)
            rd(4'(3 + 2 * k), msk(k));
        wr(4'hE, 8'h5A);
        rd(4'hE, 8'h00);
        rd(4'hF, 8'h00);
        rd(4'h1, 8'h00);
        for (int k = 0; k < 6; k++) begin
            rnd(r);
            {l, d, m, b} = {r[7:0], r[15:8], msk(k), base[k]};
            wr(4'(2 + 2 * k), l);
            wr(4'(3 + 2 * k), d);
            tick(3);
            @(negedge clk);
            chk((pin_oe[b+:8] & m) === (~d & m), "direction");
            chk((pin_out[b+:8] & ~d & m) === (l & ~d & m), "drive");
            lv = ((l & ~d) | (ext_val[b+:8] & d)) & m;
            chk((periph_pin_level[b+:8] & m) === lv, "periph level");
            rd(4'(3 + 2 * k), d & m);
            rd(4'(2 + 2 * k), lv);
            exp_oe[b+:8] = (exp_oe[b+:8] & ~m) | (~d & m);
        end
        for (int k = 0; k < 4; k++) begin
            rnd(r);
            mode <= mode_t'(k);
            sysbus_oe <= r[19:0];
            sysbus_out <= r[31:12];
            tick(3);
            @(negedge clk);
            if (k < 2) begin
                chk(pin_oe[33:14] === sysbus_oe, "bus enables");
                chk(sysbus_in === ((sysbus_oe & sysbus_out)
                    | (~sysbus_oe & ext_val[33:14])), "bus levels");
                // Bus-driven pins leave their direction bits at output
                exp_oe[33:14] = exp_oe[33:14] | sysbus_oe;
            end else
                chk(pin_oe[33:14] === exp_oe[33:14], "gp enables");
        end
        wr(4'h3, 8'hFF);
        pwm_out <= 2'h2;
        pwm_en <= 2'h3;
        tick(3);
        @(negedge clk);
        chk(pin_oe[9:8] === 2'h3, "pwm enables");
        chk(pin_out[9:8] === 2'h2, "pwm drive");
        rd(4'h3, 8'hF3);
        @(posedge clk);
        pwm_en <= 2'h0;
        wr(4'h3, 8'hFF);
        tick(3);
        @(negedge clk);
        chk(pin_oe[9:8] === 2'h0, "direction rewrite");
        wr(4'h0, 8'h08);
        tick(3);
        @(negedge clk);
        chk(pin_oe[5:0] === 6'h04, "first port enables");
        chk(pin_out[2] === 1'b0, "open drain low");
        chk(timer_clock_in === ext_val[1], "timer clock");
        chk(sync_serial_in === 2'h2, "sync serial in");
        chk(async_serial_in === ext_val[5:4], "async in");
        rd(4'h0, {2'h0, ext_val[5:4], 2'h2, ext_val[1:0]});
        wr(4'h0, 8'h04);
        tick(3);
        @(negedge clk);
        chk(pin_oe[5:0] === 6'h08, "open drain swap");
        // Board holds pin 3 low while its latch bit floats
        ext_low <= 2'h2;
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, 8'h0C);
            tick(3);
            wr(4'h1, {k[1:0], 6'h02});
            tick(3);
            @(negedge clk);
            lv6 = {ext_val[5:4], 2'h1, ext_val[1:0]};
            nl = (k == 1) ? (lv6 | 6'h04) : (k == 2) ? (lv6 & 6'h3B)
                : (k == 3) ? (lv6 ^ 6'h04) : lv6;
            chk(pin_oe[3:2] === ~nl[3:2], "bit op from levels");
        end
        ext_low <= 2'h0;
        usart_en <= 1'b1;
        usart_oe <= 2'h2;
        usart_out <= 2'h3;
        ssp_en <= 1'b1;
        ssp_drive <= 2'h1;
        tick(3);
        @(negedge clk);
        chk(pin_oe[5:2] === 4'hA, "peripheral enables");
        chk(pin_out[5] === 1'b1 && pin_out[3] === 1'b0, "peri drive");
        chk(async_serial_in[1] === 1'b1, "own drive seen");
        tick(3);
        results();
    end
endmodule

/* File: sim/pin_board.sv */
`timescale 1ns/100ps
module pin_board (
    input  wire logic [49:0] pin_out,
    input  wire logic [49:0] pin_oe,
    input  wire logic [49:0] ext_val,
    input  wire logic [1:0]  ext_low,
    output logic      [49:0] pin_in
);
    always_comb begin
        // Driven pins show the port, released ones the board value
        pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
        // Pull-ups on the open-drain pair; the board may also pull low
        pin_in[3:2] = ~((pin_oe[3:2] & ~pin_out[3:2]) | ext_low);
    end
endmodule

/* File: verilog/first_port.sv */
`timescale 1ns/100ps
module first_port
    import io_port_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   wr_latch,
    input  wire logic [5:0]             wdata,
    input  wire logic                   bitop_go,
    input  wire logic [1:0]             bitop_code,
    input  wire logic [BITOP_IDX_W-1:0] bitop_idx,
    input  wire logic                   ssp_en,
    input  wire logic [1:0]             ssp_drive,
    input  wire logic                   usart_en,
    input  wire logic [1:0]             usart_out,
    input  wire logic [1:0]             usart_oe,
    input  wire logic [5:0]             pad_in,
    output logic      [5:0]             latch_q,
    output logic      [5:0]             level_q,
    output logic      [5:0]             pad_out_q,
    output logic      [5:0]             pad_oe_q
);
    logic [5:0] mask;
    logic [5:0] rmw_val;
    logic [1:0] od_src;
    logic [5:0] pad_oe_d;
    logic [5:0] pad_out_d;

    // Index 6 or 7 gives an empty mask: plain rewrite of pin levels
    assign mask = 6'((8'h01 << bitop_idx));
    // Starts from pin levels, so a floating open-drain pin reads back high
    assign rmw_val = (bitop_code == BITOP_SET) ? (level_q | mask) :
                     (bitop_code == BITOP_CLR) ? (level_q & ~mask) :
                     (bitop_code == BITOP_TGL) ? (level_q ^ mask) :
                     level_q; // R15

    assign od_src    = ssp_en ? ssp_drive : latch_q[3:2]; // R6 R12
    assign pad_oe_d  = {usart_en ? usart_oe : 2'h0,
                        ~od_src,
                        2'h0}; // R3 R12 R13
    assign pad_out_d = {usart_out, 2'h0, 2'h0}; // R13

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q   <= FIRST_RST;
            level_q   <= 6'h00;
            pad_out_q <= 6'h00;
            pad_oe_q  <= 6'h00;
        end else begin
            if (wr_latch) begin
                latch_q <= wdata; // R14
            end else if (bitop_go) begin
                latch_q <= rmw_val; // R15
            end
            level_q   <= pad_in;
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
        end
    end
endmodule

/* File: verilog/gp_port.sv */
`timescale 1ns/100ps
module gp_port #(
    parameter int         WIDTH      = 8,
    parameter logic [7:0] DIR_INIT   = 8'hFF,
    parameter logic [7:0] LATCH_INIT = 8'h00
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             wr_latch,
    input  wire logic             wr_dir,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] ovr_en,
    input  wire logic [WIDTH-1:0] ovr_out,
    input  wire logic [WIDTH-1:0] ovr_oe,
    input  wire logic [WIDTH-1:0] pad_in,
    output logic      [WIDTH-1:0] latch_q,
    output logic      [WIDTH-1:0] dir_q,
    output logic      [WIDTH-1:0] level_q,
    output logic      [WIDTH-1:0] pad_out_q,
    output logic      [WIDTH-1:0] pad_oe_q
);
    logic [WIDTH-1:0] forced;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] pad_oe_d;
    logic [WIDTH-1:0] pad_out_d;

    // Forced outputs leave the direction bit at output; software rewrites
    assign forced    = ovr_en & ovr_oe;
    assign dir_d     = (wr_dir ? wdata : dir_q) & ~forced; // R7
    assign pad_oe_d  = forced | (~ovr_en & ~dir_q); // R17 R2 R6
    assign pad_out_d = (ovr_en & ovr_out) | (~ovr_en & latch_q); // R6

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_q   <= LATCH_INIT[WIDTH-1:0];
            dir_q     <= DIR_INIT[WIDTH-1:0];
            level_q   <= '0;
            pad_out_q <= '0;
            pad_oe_q  <= '0;
        end else begin
            if (wr_latch) begin
                latch_q <= wdata;
            end
            dir_q     <= dir_d;
            level_q   <= pad_in; // R9
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
        end
    end
endmodule

/* File: verilog/io_port_mux_control.sv */
// Contract
// R1: Seven ports give fifty individually usable pins.
// R2: Ports two to seven each have a per-pin direction register.
// R3: First port is a six-bit latch without direction register.
// R4: Ports three to five become system bus in bus modes.
// R5: Listed ports share their pins with peripheral functions.
// R6: Enabled PWM, sync or async serial takes over its pins automatically.
// R7: A peripheral-forced pin leaves its direction bit undefined; rewrite it.
// R8: Software sets direction for input-only peripheral pins itself.
// R9: Peripheral inputs see the level the port itself drives.
// R10: First port reads return pin levels, not latch contents.
// R11: First port bit one timer clock, two-three sync, four-five async.
// R12: Owning peripherals control output enables of first port bits 2-5.
// R13: First port bits two and three are open drain.
// R14: Writing open-drain bits leaves other first port pins unaffected.
// R15: Bit set, clear, toggle read pin levels then write latch.
// R16: Software should use a shadow copy for open-drain outputs.
// R17: Direction one makes the pin input, zero makes it output.
`timescale 1ns/100ps
module io_port_mux_control (
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic [io_port_pkg::ADDR_W-1:0]  addr,
    input  wire logic [io_port_pkg::DATA_W-1:0]  wdata,
    input  wire logic                            wr_en,
    input  wire logic                            rd_en,
    output logic      [io_port_pkg::DATA_W-1:0]  rd_data,
    input  wire io_port_pkg::mode_t              mode,
    input  wire logic                            ssp_en,
    input  wire logic [1:0]                      ssp_drive,
    input  wire logic                            usart_en,
    input  wire logic [1:0]                      usart_out,
    input  wire logic [1:0]                      usart_oe,
    input  wire logic [1:0]                      pwm_en,
    input  wire logic [1:0]                      pwm_out,
    input  wire logic [io_port_pkg::BUS_W-1:0]   sysbus_out,
    input  wire logic [io_port_pkg::BUS_W-1:0]   sysbus_oe,
    output logic      [io_port_pkg::BUS_W-1:0]   sysbus_in,
    input  wire logic [io_port_pkg::PIN_COUNT-1:0] pin_in,
    output logic      [io_port_pkg::PIN_COUNT-1:0] pin_out,
    output logic      [io_port_pkg::PIN_COUNT-1:0] pin_oe,
    output logic                                 timer_clock_in,
    output logic      [1:0]                      sync_serial_in,
    output logic      [1:0]                      async_serial_in,
    output logic      [io_port_pkg::PIN_COUNT-1:0] periph_pin_level
);
    import io_port_pkg::*;

    logic [PIN_COUNT-1:0] level_all;
    logic [PIN_COUNT-1:0] latch_all;
    logic [PIN_COUNT-1:0] dir_all;
    logic [PIN_COUNT-1:0] ovr_en_all;
    logic [PIN_COUNT-1:0] ovr_out_all;
    logic [PIN_COUNT-1:0] ovr_oe_all;
    logic [NUM_GP_PORTS-1:0] we_latch;
    logic [NUM_GP_PORTS-1:0] we_dir;
    logic [DATA_W-1:0] rd_chain [0:NUM_GP_PORTS];
    logic [DATA_W-1:0] rd_data_d;
    logic              bus_mode;
    logic              wr_first;
    logic              wr_bitop;
    logic              rd_first;

    // Configuration picks external bus or general-purpose use
    assign bus_mode = (mode == MODE_MICROPROC) ||
                      (mode == MODE_EXT_MC); // R4

    // Alternate owners per pin, listed from seventh port down to first
    assign ovr_en_all  = {16'h0000, {BUS_W{bus_mode}},
                          4'h0, pwm_en, 2'h0, 6'h00}; // R4 R5 R6
    assign ovr_out_all = {16'h0000, sysbus_out,
                          4'h0, pwm_out, 2'h0, 6'h00};
    assign ovr_oe_all  = {16'h0000, sysbus_oe,
                          4'h0, 2'h3, 2'h0, 6'h00};

    assign wr_first = wr_en && (addr == OFF_FIRST_LATCH);
    assign wr_bitop = wr_en && (addr == OFF_FIRST_BITOP);
    assign rd_first = addr == OFF_FIRST_LATCH;

    first_port u_first (
        .clk        (clk),
        .rst        (rst),
        .wr_latch   (wr_first),
        .wdata      (wdata[FIRST_W-1:0]),
        .bitop_go   (wr_bitop),
        .bitop_code (wdata[BITOP_CODE_LSB +: 2]),
        .bitop_idx  (wdata[BITOP_IDX_W-1:0]),
        .ssp_en     (ssp_en),
        .ssp_drive  (ssp_drive),
        .usart_en   (usart_en),
        .usart_out  (usart_out),
        .usart_oe   (usart_oe),
        .pad_in     (pin_in[FIRST_W-1:0]),
        .latch_q    (latch_all[FIRST_W-1:0]),
        .level_q    (level_all[FIRST_W-1:0]),
        .pad_out_q  (pin_out[FIRST_W-1:0]),
        .pad_oe_q   (pin_oe[FIRST_W-1:0])
    ); // R3 R11

    // No direction register on the first port
    assign dir_all[FIRST_W-1:0] = 6'h00; // R3

    // Reads of the first port show pins, not latch
    assign rd_chain[0] = rd_first ?
                         DATA_W'(level_all[FIRST_W-1:0]) : 8'h00; // R10

    genvar k;
    generate
        for (k = 0; k < NUM_GP_PORTS; k++) begin : g_port
            localparam int W = port_width(k);
            localparam int B = port_base(k);

            assign we_latch[k] = wr_en && (addr == latch_off(k));
            assign we_dir[k]   = wr_en && (addr == dir_off(k)); // R2

            gp_port #(
                .WIDTH      (W),
                .DIR_INIT   (DIR_RST),
                .LATCH_INIT (LATCH_RST)
            ) u_port (
                .clk       (clk),
                .rst       (rst),
                .wr_latch  (we_latch[k]),
                .wr_dir    (we_dir[k]),
                .wdata     (wdata[W-1:0]),
                .ovr_en    (ovr_en_all[B +: W]),
                .ovr_out   (ovr_out_all[B +: W]),
                .ovr_oe    (ovr_oe_all[B +: W]),
                .pad_in    (pin_in[B +: W]),
                .latch_q   (latch_all[B +: W]),
                .dir_q     (dir_all[B +: W]),
                .level_q   (level_all[B +: W]),
                .pad_out_q (pin_out[B +: W]),
                .pad_oe_q  (pin_oe[B +: W])
            ); // R1 R2

            // Port reads return pin levels; direction reads the register
            assign rd_chain[k+1] = rd_chain[k] |
                ((addr == latch_off(k)) ? DATA_W'(level_all[B +: W])
                                        : 8'h00) |
                ((addr == dir_off(k))   ? DATA_W'(dir_all[B +: W])
                                        : 8'h00);
        end
    endgenerate

    // Unmapped addresses fall through the chain as zero
    assign rd_data_d = rd_en ? rd_chain[NUM_GP_PORTS] : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_data_d;
        end
    end

    // Peripheral inputs see the pad, so a port-driven level reaches them
    assign periph_pin_level = level_all; // R9 R8
    assign timer_clock_in   = level_all[PIN_TIMER_CLK]; // R11
    assign sync_serial_in   = level_all[PIN_SSP_LSB +: 2]; // R11
    assign async_serial_in  = level_all[PIN_USART_LSB +: 2]; // R11
    assign sysbus_in        = level_all[BUS_BASE +: BUS_W]; // R4

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_dir_write;
        wr_en && (addr == dir_off(4)) |=> dir_all[41:34] == $past(wdata);
    endproperty
    a_dir_write: assert property (p_dir_write) // R2
        else $error("direction write not stored");

    property p_dir_input;
        dir_all[42] |=> !pin_oe[42];
    endproperty
    a_dir_input: assert property (p_dir_input) // R17
        else $error("input direction still drives");

    property p_dir_output;
        !dir_all[43] |=> pin_oe[43] && (pin_out[43] == $past(latch_all[43]));
    endproperty
    a_dir_output: assert property (p_dir_output) // R17
        else $error("output direction does not drive latch");

    property p_bus_drive;
        bus_mode && sysbus_oe[0] |=>
            pin_oe[BUS_BASE] && (pin_out[BUS_BASE] == $past(sysbus_out[0]));
    endproperty
    a_bus_drive: assert property (p_bus_drive) // R4
        else $error("system bus does not own pin");

    property p_gp_mode;
        !bus_mode && !dir_all[BUS_BASE] |=> pin_oe[BUS_BASE];
    endproperty
    a_gp_mode: assert property (p_gp_mode) // R4
        else $error("general purpose mode lost pin control");

    property p_pwm_take;
        pwm_en[0] |=> pin_oe[8] && (pin_out[8] == $past(pwm_out[0]));
    endproperty
    a_pwm_take: assert property (p_pwm_take) // R6
        else $error("pwm did not take over pin");

    property p_force_dir;
        pwm_en[1] ##1 pwm_en[1] |-> !dir_all[9];
    endproperty
    a_force_dir: assert property (p_force_dir) // R7
        else $error("forced pin direction not output");

    property p_ssp_od;
        ssp_en |=> (pin_oe[3:2] == ~$past(ssp_drive)) &&
            (pin_out[3:2] == 2'h0);
    endproperty
    a_ssp_od: assert property (p_ssp_od) // R13
        else $error("open drain pin driven wrongly by sync serial");

    property p_od_latch;
        (!ssp_en && wr_first) ##1 !ssp_en |=>
            pin_oe[2] == !$past(wdata[2], 2);
    endproperty
    a_od_latch: assert property (p_od_latch) // R13
        else $error("open drain latch write wrong");

    property p_first_read;
        rd_en && rd_first |=> rd_data == {2'h0, $past(level_all[5:0])};
    endproperty
    a_first_read: assert property (p_first_read) // R10
        else $error("first port read is not pin level");

    property p_first_inputs;
        pin_oe[1:0] == 2'h0;
    endproperty
    a_first_inputs: assert property (p_first_inputs) // R3
        else $error("input-only first port pin drives");

    property p_usart_owner;
        !usart_en |=> pin_oe[5:4] == 2'h0;
    endproperty
    a_usart_owner: assert property (p_usart_owner) // R12
        else $error("async serial pins drive while module off");

    property p_isolate;
        wr_first && !usart_en ##1 !usart_en |=>
            $stable(pin_oe[5:4]) && $stable(pin_oe[1:0]);
    endproperty
    a_isolate: assert property (p_isolate) // R14
        else $error("open drain write disturbed other pins");

    property p_rmw_set;
        wr_bitop && (wdata[7:6] == BITOP_SET) && (wdata[2:0] == 3'h2) |=>
            latch_all[5:0] == ($past(level_all[5:0]) | 6'h04);
    endproperty
    a_rmw_set: assert property (p_rmw_set) // R15
        else $error("bit set did not use pin levels");

    property p_timer_pin;
        pin_in[PIN_TIMER_CLK] |=> timer_clock_in ##1
            level_all[1] == $past(pin_in[1]);
    endproperty
    a_timer_pin: assert property (p_timer_pin) // R11
        else $error("timer clock pin not forwarded");

    property p_usart_drive;
        usart_en |=> (pin_oe[5:4] == $past(usart_oe)) &&
            (pin_out[5:4] == $past(usart_out));
    endproperty
    a_usart_drive: assert property (p_usart_drive) // R12
        else $error("async serial does not own its pins");

    property p_async_in;
        usart_en |=> async_serial_in == $past(pin_in[5:4]);
    endproperty
    a_async_in: assert property (p_async_in) // R9
        else $error("async serial input not the pin level");

    property p_port_read;
        rd_en && (addr == latch_off(0)) |=>
            rd_data == $past(level_all[13:6]);
    endproperty
    a_port_read: assert property (p_port_read) // R1
        else $error("port read is not pin level");

    property p_dir_read;
        rd_en && (addr == dir_off(0)) |=> rd_data == $past(dir_all[13:6]);
    endproperty
    a_dir_read: assert property (p_dir_read) // R2
        else $error("direction read wrong");

    property p_first_write;
        wr_first |=> latch_all[5:0] == $past(wdata[5:0]);
    endproperty
    a_first_write: assert property (p_first_write) // R14
        else $error("first port write not stored");

    property p_rmw_clear;
        wr_bitop && (wdata[7:6] == BITOP_CLR) && (wdata[2:0] == 3'h2) |=>
            latch_all[5:0] == ($past(level_all[5:0]) & 6'h3B);
    endproperty
    a_rmw_clear: assert property (p_rmw_clear) // R15
        else $error("bit clear did not use pin levels");

    property p_gp_drive;
        !bus_mode && !dir_all[BUS_BASE] |=>
            pin_out[BUS_BASE] == $past(latch_all[BUS_BASE]);
    endproperty
    a_gp_drive: assert property (p_gp_drive) // R4
        else $error("general purpose pin does not drive latch");

    c_bus_mode: cover property (bus_mode ##1 pin_oe[BUS_BASE]);
    c_pwm_on:   cover property (pwm_en[0] ##1 pin_oe[8]);
    c_ssp_low:  cover property (ssp_en && !ssp_drive[0] ##1 pin_oe[2]);
    c_rmw_tgl:  cover property (wr_bitop && (wdata[7:6] == BITOP_TGL));
endmodule

/* File: verilog/io_port_pkg.sv */
package io_port_pkg;

    localparam int NUM_PORTS     = 7;
    localparam int PIN_COUNT     = 50;
    localparam int NUM_GP_PORTS  = 6;
    localparam int FIRST_W       = 6;
    localparam int ADDR_W        = 4;
    localparam int DATA_W        = 8;

    // Register map
    localparam logic [ADDR_W-1:0] OFF_FIRST_LATCH = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_FIRST_BITOP = 4'h1;
    localparam int                OFF_PORT_BASE   = 2;

    // Values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST   = 8'hFF;
    localparam logic [5:0] FIRST_RST = 6'h00;

    // Bit operation register layout and codes
    localparam int         BITOP_CODE_LSB = 6;
    localparam int         BITOP_IDX_W    = 3;
    localparam logic [1:0] BITOP_REWRITE  = 2'h0;
    localparam logic [1:0] BITOP_SET      = 2'h1;
    localparam logic [1:0] BITOP_CLR      = 2'h2;
    localparam logic [1:0] BITOP_TGL      = 2'h3;

    // Pin positions
    localparam int PIN_TIMER_CLK = 1;
    localparam int PIN_SSP_LSB   = 2;
    localparam int PIN_USART_LSB = 4;
    localparam int BUS_BASE      = 14;
    localparam int BUS_W         = 20;

    typedef enum logic [1:0] {
        MODE_MICROPROC = 2'h0,
        MODE_EXT_MC    = 2'h1,
        MODE_MC        = 2'h2,
        MODE_PROT_MC   = 2'h3
    } mode_t;

    // k = 0..5 stands for the second through seventh port
    function automatic int port_width(input int k);
        return (k == 3) ? 4 : 8;
    endfunction

    function automatic int port_base(input int k);
        return FIRST_W + 8 * k - ((k > 3) ? 4 : 0);
    endfunction

    function automatic logic [ADDR_W-1:0] latch_off(input int k);
        return ADDR_W'(OFF_PORT_BASE + 2 * k);
    endfunction

    function automatic logic [ADDR_W-1:0] dir_off(input int k);
        return ADDR_W'(OFF_PORT_BASE + 2 * k + 1);
    endfunction

endpackage
